/* cpu_pkg.sv */
// constants, types and state record of the command pulse unit
package cpu_pkg;

    // memory geometry and fixed locations
    localparam int CPU_ADDR_W = 10;
    localparam logic [9:0] CPU_BB_BASE = 10'h000;     // shared back-end buffer
    localparam logic [9:0] CPU_BUF_BASE = 10'h100;    // private packet buffer
    localparam logic [9:0] CPU_ROM_ID_HI = 10'h006;   // header octet 1 reference
    localparam logic [9:0] CPU_ROM_ID_LO = 10'h007;   // header octet 2 reference

    // packet layout and clean limits
    localparam logic [7:0] CPU_HDR_OCTETS = 8'h06;
    localparam logic [7:0] CPU_LEN_ADJ = 8'h07;       // length field + 7 = octets
    localparam logic [7:0] CPU_LEN_MIN = 8'h0A;       // 10 octets
    localparam logic [7:0] CPU_LEN_MAX_FULL = 8'hF8;  // 248 octets, 120 instructions
    localparam logic [7:0] CPU_LEN_MAX_TAIL = 8'hEE;  // 238 octets, 115 instructions
    localparam logic [7:0] CPU_CRC_OCTETS = 8'h02;
    localparam logic [7:0] CPU_INSTR_OCTETS = 8'h02;
    localparam logic [1:0] CPU_SEQ_UNSEG = 2'h3;
    localparam logic [5:0] CPU_AP_ZERO = 6'h00;

    // frame error control crc
    localparam logic [15:0] CPU_CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CPU_CRC_POLY = 16'h1021;
    localparam logic [15:0] CPU_CRC_GOOD = 16'h0000;

    // status word
    localparam logic [15:0] CPU_STAT_RESET = 16'h3FFF;  // cold start
    localparam logic [1:0] CPU_ST_LEGAL = 2'h1;
    localparam logic [1:0] CPU_ST_ILLEGAL = 2'h2;
    localparam logic [1:0] CPU_ST_DIRTY = 2'h3;

    // pulse timing base, in clock periods
    localparam int CPU_CNT_W = 24;
    localparam int CPU_DIV0_CYCLES = 32'h0000_A000;     // 40960
    localparam int CPU_DIV1_CYCLES = 32'h0000_2000;     // 8192

    // segment offered by the segment layer
    typedef struct packed {
        logic valid;
        logic [5:0] map_id;
        logic [1:0] seq_flags;
        logic [7:0] octets;       // packet octets in the back-end buffer
        logic authenticated;
    } cpu_seg_s;

    // static configuration straps
    typedef struct packed {
        logic pulse_time_divider_select;
        logic auth_disable;
        logic auth_external_select;
        logic auth_tail_option;
    } cpu_cfg_s;

    typedef enum logic [4:0] {
        CPU_IDLE = 5'h00,
        CPU_C_RD = 5'h01,
        CPU_C_RDW = 5'h02,
        CPU_C_WR = 5'h03,
        CPU_C_RB = 5'h04,
        CPU_C_RBW = 5'h05,
        CPU_C_CRC = 5'h06,
        CPU_L_R6 = 5'h07,
        CPU_L_W6 = 5'h08,
        CPU_L_D6 = 5'h09,
        CPU_L_W7 = 5'h0A,
        CPU_L_D7 = 5'h0B,
        CPU_ERASE = 5'h0C,
        CPU_X_R1 = 5'h0D,
        CPU_X_W1 = 5'h0E,
        CPU_X_D1 = 5'h0F,
        CPU_X_W2 = 5'h10,
        CPU_X_D2 = 5'h11,
        CPU_PULSE = 5'h12
    } cpu_state_e;

    // whole state of the unit
    typedef struct packed {
        cpu_state_e state;
        logic [7:0] idx;
        logic [7:0] octets;
        logic [7:0] max_octets;
        logic [1:0] seq_flags;
        logic [15:0] crc;
        logic [5:0][7:0] hdr;
        logic [7:0] data;
        logic [7:0] sel;
        logic [CPU_CNT_W-1:0] cnt;
        logic pulse;
        logic [15:0] status;
        logic [9:0] ram_addr;
        logic ram_rd;
        logic ram_wr;
        logic [7:0] ram_wdata;
        logic [9:0] rom_addr;
        logic rom_rd;
        logic ack;
    } cpu_state_s;

endpackage : cpu_pkg

/* cpu_command_pulse_unit.sv */
// command pulse unit: packet copy, clean and legal checks, timed pulse execution
`timescale 1ns/1ps
module cpu_command_pulse_unit #(
    parameter int DIV0_CYCLES = cpu_pkg::CPU_DIV0_CYCLES,
    parameter int DIV1_CYCLES = cpu_pkg::CPU_DIV1_CYCLES
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // segment layer
    input wire cpu_pkg::cpu_seg_s seg_in,
    input wire cpu_pkg::cpu_cfg_s cfg_in,
    output logic seg_ack_out,
    output logic ap_zero_claim_out,
    output logic busy_out,
    // external ram: back-end buffer and private buffer
    output logic [cpu_pkg::CPU_ADDR_W-1:0] ram_addr_out,
    output logic ram_rd_out,
    output logic ram_wr_out,
    output logic [7:0] ram_wdata_out,
    input wire logic [7:0] ram_rdata_in,
    // external rom
    output logic [cpu_pkg::CPU_ADDR_W-1:0] rom_addr_out,
    output logic rom_rd_out,
    input wire logic [7:0] rom_data_in,
    // pulse demultiplexer and status
    output logic [7:0] pulse_select_out,
    output logic pulse_output_strobe_out,
    output logic [15:0] pulse_unit_status_out
);
    import cpu_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // one octet through the frame crc, msb first
    function automatic logic [15:0] crc_octet(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc;
        for (int i = 7; i >= 0; i--) begin
            if (c[15] ^ b[i]) begin
                c = {c[14:0], 1'b0} ^ CPU_CRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction : crc_octet

    // pulse length in clocks: base period shifted by the duration code
    function automatic logic [CPU_CNT_W-1:0] pulse_cycles(input logic div_sel,
                                                          input logic [2:0] x);
        logic [CPU_CNT_W-1:0] base;
        base = div_sel ? CPU_CNT_W'(DIV1_CYCLES) : CPU_CNT_W'(DIV0_CYCLES);
        return base << x;
    endfunction : pulse_cycles

    // buffer address of a packet octet
    function automatic logic [9:0] buf_addr(input logic [9:0] base, input logic [7:0] i);
        return 10'(base + {2'b00, i});
    endfunction : buf_addr

    ////////////////////////////////////////////////////////////////////////
    // state

    // state record and next value
    cpu_state_s s_q;
    cpu_state_s s_d;

    // decoded helpers
    logic copying;
    logic auth_ok;
    logic internal_auth;
    logic ap_zero;
    logic [15:0] crc_next;
    logic clean;
    logic legal_hi;

    // segment routing and admission
    assign ap_zero = seg_in.valid && (seg_in.map_id == CPU_AP_ZERO);
    assign ap_zero_claim_out = ap_zero;

    // authentication gate
    assign internal_auth = !cfg_in.auth_disable && !cfg_in.auth_external_select;
    assign auth_ok = seg_in.authenticated || !internal_auth;
    // copy in flight
    assign copying = (s_q.state inside {CPU_C_RD, CPU_C_RDW, CPU_C_WR, CPU_C_RB,
                                        CPU_C_RBW, CPU_C_CRC});

    // crc of the read-back octet and the clean verdict on the last one
    assign crc_next = crc_octet(s_q.crc, ram_rdata_in);
    assign clean = (crc_next == CPU_CRC_GOOD)
        && (s_q.seq_flags == CPU_SEQ_UNSEG)
        && !s_q.octets[0]
        && (s_q.octets >= CPU_LEN_MIN)
        && (s_q.octets <= s_q.max_octets)
        && (s_q.hdr[4] == 8'h00)
        && (8'(s_q.hdr[5] + CPU_LEN_ADJ) == s_q.octets);
    // first id byte match
    assign legal_hi = (s_q.hdr[0] == rom_data_in);

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_d = s_q;
        s_d.ram_rd = 1'b0;
        s_d.ram_wr = 1'b0;
        s_d.rom_rd = 1'b0;
        s_d.ack = 1'b0;

        // drop a segment that cannot be taken now; the held one is never dropped
        if (ap_zero && !copying && !s_q.ack &&
            ((s_q.state != CPU_IDLE) || !auth_ok)) begin
            s_d.ack = 1'b1;
        end

        unique case (s_q.state)
            CPU_IDLE: begin
                s_d.pulse = 1'b0;
                if (ap_zero && auth_ok && !s_q.ack) begin
                    if (seg_in.octets == 8'h00) begin
                        s_d.ack = 1'b1;
                        s_d.status[15:14] = CPU_ST_DIRTY;
                    end else begin
                        s_d.state = CPU_C_RD;
                        s_d.idx = 8'h00;
                        s_d.octets = seg_in.octets;
                        s_d.seq_flags = seg_in.seq_flags;
                        s_d.crc = CPU_CRC_INIT;
                        if (cfg_in.auth_disable ||
                            (cfg_in.auth_external_select && cfg_in.auth_tail_option)) begin
                            s_d.max_octets = CPU_LEN_MAX_FULL;
                        end else begin
                            s_d.max_octets = CPU_LEN_MAX_TAIL;
                        end
                    end
                end
            end

            // copy: read shared buffer, write private buffer, read it back
            CPU_C_RD: begin
                s_d.ram_rd = 1'b1;
                s_d.ram_addr = buf_addr(CPU_BB_BASE, s_q.idx);
                s_d.state = CPU_C_RDW;
            end
            CPU_C_RDW: begin
                // ram data next
                s_d.state = CPU_C_WR;
            end
            CPU_C_WR: begin
                s_d.ram_wr = 1'b1;
                s_d.ram_addr = buf_addr(CPU_BUF_BASE, s_q.idx);
                s_d.ram_wdata = ram_rdata_in;
                s_d.state = CPU_C_RB;
            end
            CPU_C_RB: begin
                s_d.ram_rd = 1'b1;
                s_d.ram_addr = buf_addr(CPU_BUF_BASE, s_q.idx);
                s_d.state = CPU_C_RBW;
            end
            CPU_C_RBW: begin
                // read-back next
                s_d.state = CPU_C_CRC;
            end
            CPU_C_CRC: begin
                s_d.crc = crc_next;
                if (s_q.idx < CPU_HDR_OCTETS) begin
                    s_d.hdr[s_q.idx[2:0]] = ram_rdata_in;
                end
                s_d.idx = 8'(s_q.idx + 8'h01);
                if (8'(s_q.idx + 8'h01) == s_q.octets) begin
                    s_d.ack = 1'b1;
                    s_d.idx = 8'h00;
                    if (clean) begin
                        s_d.state = CPU_L_R6;
                    end else begin
                        s_d.status[15:14] = CPU_ST_DIRTY;
                        s_d.state = CPU_ERASE;
                    end
                end else begin
                    s_d.state = CPU_C_RD;
                end
            end

            // legal check of the header against the rom identifier bytes
            CPU_L_R6: begin
                s_d.rom_rd = 1'b1;
                s_d.rom_addr = CPU_ROM_ID_HI;
                s_d.state = CPU_L_W6;
            end
            CPU_L_W6: begin
                // rom data next
                s_d.state = CPU_L_D6;
            end
            CPU_L_D6: begin
                s_d.data = {7'h00, legal_hi};
                s_d.rom_rd = 1'b1;
                s_d.rom_addr = CPU_ROM_ID_LO;
                s_d.state = CPU_L_W7;
            end
            CPU_L_W7: begin
                // second byte next
                s_d.state = CPU_L_D7;
            end
            CPU_L_D7: begin
                // sequence count is reported, never compared
                if (s_q.data[0] && (s_q.hdr[1] == rom_data_in) &&
                    (s_q.hdr[2][7:6] == CPU_SEQ_UNSEG)) begin
                    s_d.status = {CPU_ST_LEGAL, s_q.hdr[2][5:0], s_q.hdr[3]};
                    s_d.idx = CPU_HDR_OCTETS;
                    s_d.state = CPU_X_R1;
                end else begin
                    s_d.status[15:14] = CPU_ST_ILLEGAL;
                    s_d.state = CPU_ERASE;
                end
            end

            // wipe the private buffer of a rejected packet
            CPU_ERASE: begin
                // one octet a cycle
                s_d.ram_wr = 1'b1;
                s_d.ram_addr = buf_addr(CPU_BUF_BASE, s_q.idx);
                s_d.ram_wdata = 8'h00;
                s_d.idx = 8'(s_q.idx + 8'h01);
                if (8'(s_q.idx + 8'h01) == s_q.octets) begin
                    s_d.state = CPU_IDLE;
                end
            end

            // fetch one instruction: output select, then duration
            CPU_X_R1: begin
                s_d.ram_rd = 1'b1;
                s_d.ram_addr = buf_addr(CPU_BUF_BASE, s_q.idx);
                s_d.state = CPU_X_W1;
            end
            CPU_X_W1: begin
                // select next
                s_d.state = CPU_X_D1;
            end
            CPU_X_D1: begin
                s_d.data = ram_rdata_in;
                s_d.ram_rd = 1'b1;
                s_d.ram_addr = buf_addr(CPU_BUF_BASE, 8'(s_q.idx + 8'h01));
                s_d.state = CPU_X_W2;
            end
            CPU_X_W2: begin
                // duration next
                s_d.state = CPU_X_D2;
            end
            CPU_X_D2: begin
                s_d.sel = s_q.data;
                s_d.cnt = pulse_cycles(cfg_in.pulse_time_divider_select,
                                       ram_rdata_in[2:0]);
                s_d.pulse = 1'b1;
                s_d.state = CPU_PULSE;
            end

            // strobe stands while the counter runs, then the next instruction
            CPU_PULSE: begin
                if (s_q.cnt == CPU_CNT_W'(1)) begin
                    s_d.pulse = 1'b0;
                    s_d.idx = 8'(s_q.idx + CPU_INSTR_OCTETS);
                    if (8'(s_q.idx + CPU_INSTR_OCTETS) <
                        8'(s_q.octets - CPU_CRC_OCTETS)) begin
                        s_d.state = CPU_X_R1;
                    end else begin
                        s_d.state = CPU_IDLE;
                    end
                end else begin
                    s_d.cnt = CPU_CNT_W'(s_q.cnt - CPU_CNT_W'(1));
                end
            end

            default: begin
                s_d.state = CPU_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
            s_q.state <= CPU_IDLE;
            s_q.crc <= CPU_CRC_INIT;
            s_q.max_octets <= CPU_LEN_MAX_FULL;
            s_q.status <= CPU_STAT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    // busy spans copy, checks and execution
    assign busy_out = (s_q.state != CPU_IDLE);
    assign seg_ack_out = s_q.ack;

    // memory strobes, all registered
    assign ram_addr_out = s_q.ram_addr;
    assign ram_rd_out = s_q.ram_rd;
    assign ram_wr_out = s_q.ram_wr;
    assign ram_wdata_out = s_q.ram_wdata;
    assign rom_addr_out = s_q.rom_addr;
    assign rom_rd_out = s_q.rom_rd;

    assign pulse_select_out = s_q.sel;
    assign pulse_output_strobe_out = s_q.pulse;
    assign pulse_unit_status_out = s_q.status;

endmodule : cpu_command_pulse_unit

/* cpu_mem_model.sv */
// external ram and rom partner of the command pulse unit
`timescale 1ns/1ps
module cpu_mem_model #(
    parameter logic [7:0] ID_HI = 8'h1A,  // arbitrary identifier byte
    parameter logic [7:0] ID_LO = 8'h5C   // arbitrary identifier byte
) (
    // clock
    input wire logic core_clk_in,
    // ram port
    input wire logic [9:0] ram_addr_in,
    input wire logic ram_rd_in,
    input wire logic ram_wr_in,
    input wire logic [7:0] ram_wdata_in,
    output logic [7:0] ram_rdata_out,
    // rom port
    input wire logic [9:0] rom_addr_in,
    input wire logic rom_rd_in,
    output logic [7:0] rom_data_out
);
    logic [7:0] mem [0:1023];
    initial begin
        ram_rdata_out = 8'h00;
        rom_data_out = 8'h00;
    end
    // data only in the cycle after a read strobe, a toggling pattern otherwise
    always @(posedge core_clk_in) begin
        if (ram_wr_in) begin
            mem[ram_addr_in] <= ram_wdata_in;
        end
        ram_rdata_out <= ram_rd_in ? mem[ram_addr_in] : ~ram_rdata_out;
        rom_data_out <= !rom_rd_in ? ~rom_data_out : rom_addr_in == 10'h006 ? ID_HI :
                        rom_addr_in == 10'h007 ? ID_LO : 8'hA5;
    end
endmodule : cpu_mem_model

/* cpu_monitor.sv */
// concurrent checks on the command pulse unit ports
`timescale 1ns/1ps
module cpu_monitor #(
    parameter int DIV0_CYCLES = 8,
    parameter int DIV1_CYCLES = 4
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // segment layer
    input wire cpu_pkg::cpu_seg_s seg_in,
    input wire cpu_pkg::cpu_cfg_s cfg_in,
    input wire logic seg_ack_out,
    input wire logic ap_zero_claim_out,
    input wire logic busy_out,
    // memories
    input wire logic [9:0] ram_addr_out,
    input wire logic ram_rd_out,
    input wire logic ram_wr_out,
    input wire logic [7:0] ram_wdata_out,
    input wire logic [7:0] ram_rdata_in,
    input wire logic [9:0] rom_addr_out,
    input wire logic rom_rd_out,
    // pulse outputs
    input wire logic [7:0] pulse_select_out,
    input wire logic pulse_output_strobe_out,
    input wire logic [15:0] pulse_unit_status_out
);
    import cpu_pkg::*;
    localparam int MAX_LEN = (DIV0_CYCLES > DIV1_CYCLES ? DIV0_CYCLES : DIV1_CYCLES) * 128;
    logic [31:0] len_q;
    logic [31:0] len_d;
    // cycles the strobe has been high so far
    always_comb len_d = pulse_output_strobe_out ? len_q + 32'h0000_0001 : 32'h0000_0000;
    always_ff @(posedge core_clk_in) len_q <= rst_n_in ? len_d : 32'h0000_0000;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////////////
    // copy steps of one octet: fetch, store, read back
    sequence s_fetch;
        ram_rd_out && ram_addr_out[9:8] == 2'h0;
    endsequence
    sequence s_store;
        ram_wr_out && ram_addr_out == $past(ram_addr_out, 2) + CPU_BUF_BASE &&
            ram_wdata_out == $past(ram_rdata_in);
    endsequence
    sequence s_readback;
        ram_rd_out && ram_addr_out == $past(ram_addr_out);
    endsequence
    property p_copy;
        s_fetch |-> ##2 s_store ##1 s_readback;
    endproperty
    a_copy: assert property (p_copy) else $error("octet copy steps broken");
    property p_claim;
        ap_zero_claim_out == (seg_in.valid && seg_in.map_id == CPU_AP_ZERO);
    endproperty
    a_claim: assert property (p_claim) else $error("claim mismatch");
    property p_drop;
        pulse_output_strobe_out && seg_in.valid && seg_in.map_id == CPU_AP_ZERO && !seg_ack_out
            |=> seg_ack_out && (busy_out || $fell(pulse_output_strobe_out));
    endproperty
    a_drop: assert property (p_drop) else $error("busy segment not dropped");
    property p_auth;
        !busy_out && seg_in.valid && seg_in.map_id == CPU_AP_ZERO && !seg_in.authenticated &&
            !cfg_in.auth_disable && !cfg_in.auth_external_select && !seg_ack_out
            |=> seg_ack_out && !busy_out;
    endproperty
    a_auth: assert property (p_auth) else $error("unauthenticated accepted");
    property p_exec;
        pulse_output_strobe_out |-> busy_out && pulse_unit_status_out[15:14] == CPU_ST_LEGAL;
    endproperty
    a_exec: assert property (p_exec) else $error("pulse without legal packet");
    property p_sel_hold;
        pulse_output_strobe_out && $past(pulse_output_strobe_out) |-> $stable(pulse_select_out);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select moved in pulse");
    property p_sel_rise;
        $changed(pulse_select_out) |-> $rose(pulse_output_strobe_out);
    endproperty
    a_sel_rise: assert property (p_sel_rise) else $error("select moved off rise");
    property p_min;
        $rose(pulse_output_strobe_out) |-> pulse_output_strobe_out[*4];
    endproperty
    a_min: assert property (p_min) else $error("pulse too short");
    property p_max;
        pulse_output_strobe_out |-> len_q < MAX_LEN;
    endproperty
    a_max: assert property (p_max) else $error("pulse too long");
    property p_rom;
        rom_rd_out |-> rom_addr_out == CPU_ROM_ID_HI || rom_addr_out == CPU_ROM_ID_LO;
    endproperty
    a_rom: assert property (p_rom) else $error("rom read off id bytes");
endmodule : cpu_monitor
bind cpu_command_pulse_unit cpu_monitor #(.DIV0_CYCLES(DIV0_CYCLES), .DIV1_CYCLES(DIV1_CYCLES))
    u_mon (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .seg_in(seg_in), .cfg_in(cfg_in),
    .seg_ack_out(seg_ack_out), .ap_zero_claim_out(ap_zero_claim_out), .busy_out(busy_out),
    .ram_addr_out(ram_addr_out), .ram_rd_out(ram_rd_out), .ram_wr_out(ram_wr_out),
    .ram_wdata_out(ram_wdata_out), .ram_rdata_in(ram_rdata_in), .rom_addr_out(rom_addr_out),
    .rom_rd_out(rom_rd_out), .pulse_select_out(pulse_select_out),
    .pulse_output_strobe_out(pulse_output_strobe_out),
    .pulse_unit_status_out(pulse_unit_status_out));

/* cpu_command_pulse_unit_bench.sv */
// self-checking bench for the command pulse unit
`timescale 1ns/1ps
module cpu_command_pulse_unit_bench;
    import cpu_pkg::*;
    localparam int D0 = 8;
    localparam int D1 = 4;
    localparam logic [7:0] ID_HI = 8'h1A;  // arbitrary identifier byte
    localparam logic [7:0] ID_LO = 8'h5C;  // arbitrary identifier byte
    logic core_clk_in, rst_n_in, seg_ack, claim, busy, ram_rd, ram_wr, rom_rd, strobe;
    cpu_seg_s seg;
    cpu_cfg_s cfg;
    logic [9:0] ram_addr, rom_addr;
    logic [7:0] ram_wdata, ram_rdata, rom_data, sel, p_sel;
    logic [15:0] status, last_stat;
    logic [7:0] pkt [0:255];
    logic [7:0] q_sel [$];
    int q_len [$];
    logic [15:0] q_stat [$];
    int fail_count, num_checks, p_cnt;
    int unsigned seed;
    bit s_prev, b_prev;
    ////////////////////////////////////////////////////////////////////////////////
    // design and memory partner
    cpu_command_pulse_unit #(.DIV0_CYCLES(D0), .DIV1_CYCLES(D1)) dut (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .seg_in(seg), .cfg_in(cfg),
        .seg_ack_out(seg_ack), .ap_zero_claim_out(claim), .busy_out(busy),
        .ram_addr_out(ram_addr), .ram_rd_out(ram_rd), .ram_wr_out(ram_wr),
        .ram_wdata_out(ram_wdata), .ram_rdata_in(ram_rdata), .rom_addr_out(rom_addr),
        .rom_rd_out(rom_rd), .rom_data_in(rom_data), .pulse_select_out(sel),
        .pulse_output_strobe_out(strobe), .pulse_unit_status_out(status));
    cpu_mem_model #(.ID_HI(ID_HI), .ID_LO(ID_LO)) u_mem (
        .core_clk_in(core_clk_in), .ram_addr_in(ram_addr), .ram_rd_in(ram_rd),
        .ram_wr_in(ram_wr), .ram_wdata_in(ram_wdata), .ram_rdata_out(ram_rdata),
        .rom_addr_in(rom_addr), .rom_rd_in(rom_rd), .rom_data_out(rom_data));
    // clock
    initial begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // comparison, verdict and bounded waits
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    function automatic bit cond(input int w);
        return w == 0 ? seg_ack === 1'b1 : w == 1 ? strobe === 1'b1 : busy === 1'b0;
    endfunction : cond
    task automatic wait_for(input int w, input int lim);
        int k;
        k = 0;
        do begin
            @(negedge core_clk_in);
            k++;
        end while (!cond(w) && k < lim);
        if (!cond(w)) begin
            check("wait", 1, 0);
            conclude();
        end
    endtask : wait_for
    // offer one segment and hold it until acknowledged
    task automatic offer(input logic [1:0] f, input logic [7:0] o, input logic a);
        @(posedge core_clk_in);
        seg <= '{1'b1, CPU_AP_ZERO, f, o, a};
        wait_for(0, 3000);
        @(posedge core_clk_in);
        seg.valid <= 1'b0;
    endtask : offer
    task automatic set_cfg(input logic d, input logic dis, input logic ext, input logic tail);
        @(posedge core_clk_in);
        cfg <= '{d, dis, ext, tail};
        @(negedge core_clk_in);
    endtask : set_cfg
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        for (int b = 7; b >= 0; b--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? CPU_CRC_POLY : 16'h0000);
        end
        return c;
    endfunction : crc_step
    // build a packet with one fault kind, load it, note the results and send it
    task automatic run(input int n, input int fault, input logic [1:0] fl, input logic a,
                       input bit drop);
        int o;
        int mx;
        logic [15:0] c;
        bit clean;
        o = 8 + 2 * n + (fault == 6);
        pkt[0] = (fault == 2) ? ~ID_HI : ID_HI;
        pkt[1] = ID_LO;
        pkt[2] = {(fault == 3) ? 2'h1 : CPU_SEQ_UNSEG, 6'($urandom)};
        pkt[3] = 8'($urandom);
        pkt[4] = (fault == 5) ? 8'h01 : 8'h00;
        pkt[5] = 8'(o - 7 + ((fault == 4) ? 2 : 0));
        c = CPU_CRC_INIT;
        for (int i = 0; i < o - 2; i++) begin
            if (i > 5) begin
                pkt[i] = 8'($urandom) & ((i % 2 == 1 && n > 8) ? 8'hF8 : 8'hFF);
            end
            c = crc_step(c, pkt[i]);
        end
        pkt[o - 2] = c[15:8] ^ ((fault == 1) ? 8'h01 : 8'h00);
        pkt[o - 1] = c[7:0];
        for (int i = 0; i < o; i++) begin
            u_mem.mem[i] = pkt[i];
        end
        mx = (cfg.auth_disable || (cfg.auth_external_select && cfg.auth_tail_option)) ? 248 : 238;
        clean = (fault == 0 || fault == 2 || fault == 3) && fl == CPU_SEQ_UNSEG && o <= mx;
        if (!a && !cfg.auth_disable && !cfg.auth_external_select) begin
            offer(fl, 8'(o), a);
            check("status kept", last_stat, status);
            return;
        end
        if (clean && fault == 0) begin
            last_stat = {CPU_ST_LEGAL, pkt[2][5:0], pkt[3]};
            for (int i = 0; i < n; i++) begin
                q_sel.push_back(pkt[6 + 2 * i]);
                q_len.push_back((cfg.pulse_time_divider_select ? D1 : D0) << pkt[7 + 2 * i][2:0]);
            end
        end else begin
            last_stat[15:14] = clean ? CPU_ST_ILLEGAL : CPU_ST_DIRTY;
        end
        q_stat.push_back(last_stat);
        offer(fl, 8'(o), a);
        if (drop) begin
            wait_for(1, 4000);
            offer(fl, 8'(o), a);
        end
        wait_for(2, 40000);
    endtask : run
    ////////////////////////////////////////////////////////////////////////////////
    // compare each finished pulse and status word with the oldest note
    always @(negedge core_clk_in) begin
        if (strobe === 1'b1 && !s_prev) begin
            p_sel = sel;
            p_cnt = 0;
        end
        if (strobe === 1'b1) begin
            p_cnt++;
        end
        if (s_prev && strobe !== 1'b1) begin
            if (q_len.size() == 0) begin
                check("pulse count", 0, 1);
            end else begin
                check("pulse select", q_sel.pop_front(), p_sel);
                check("pulse length", q_len.pop_front(), p_cnt);
            end
        end
        if (b_prev && busy !== 1'b1) begin
            check("status", q_stat.size() ? q_stat.pop_front() : 32'hFFFF_FFFF, status);
        end
        s_prev = strobe === 1'b1;
        b_prev = busy === 1'b1;
    end
    // main sequence
    initial begin
        seg = '0;
        cfg = '{1'b0, 1'b1, 1'b0, 1'b0};
        rst_n_in = 1'b0;
        last_stat = CPU_STAT_RESET;
        seed = $urandom(42720);
        repeat (10) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        @(negedge core_clk_in);
        check("reset status", CPU_STAT_RESET, status);
        run(3, 0, 2'h3, 1'b1, 1'b0);
        run(2, 0, 2'h3, 1'b1, 1'b1);
        for (int f = 1; f < 7; f++) begin
            run(1, f, 2'h3, 1'b1, 1'b0);
        end
        run(1, 0, 2'h1, 1'b1, 1'b0);
        set_cfg(1'b1, 1'b1, 1'b0, 1'b0);
        run(120, 0, 2'h3, 1'b1, 1'b0);
        set_cfg(1'b0, 1'b0, 1'b0, 1'b0);
        run(120, 0, 2'h3, 1'b1, 1'b0);
        run(115, 0, 2'h3, 1'b1, 1'b0);
        run(1, 0, 2'h3, 1'b0, 1'b0);
        set_cfg(1'b1, 1'b0, 1'b1, 1'b1);
        run(120, 0, 2'h3, 1'b0, 1'b0);
        set_cfg(1'b1, 1'b0, 1'b1, 1'b0);
        run(116, 0, 2'h3, 1'b1, 1'b0);
        @(posedge core_clk_in);
        seg <= '{1'b1, 6'h05, 2'h3, 8'h0A, 1'b1};
        repeat (3) @(posedge core_clk_in);
        seg.valid <= 1'b0;
        repeat (4) @(negedge core_clk_in);
        check("notes left", 0, q_len.size() + q_stat.size());
        conclude();
    end
endmodule : cpu_command_pulse_unit_bench
